// file: inc/pafe_pkg.sv
package pafe_pkg;
  // table geometry
  localparam int NPORT = 3;
  localparam int NENT = 16;
  localparam int TBL_AW = 7;
  localparam int TBL_WORDS = 128;
  // word slots inside one table entry
  localparam logic [2:0] W_M0 = 3'h0;
  localparam logic [2:0] W_M1 = 3'h1;
  localparam logic [2:0] W_M2 = 3'h2;
  localparam logic [2:0] W_ACT = 3'h3;
  localparam logic [2:0] W_PROC = 3'h4;
  // byte offsets
  localparam logic [11:0] ADR_CTRL = 12'h000;
  localparam logic [11:0] ADR_RSVD = 12'h004;
  localparam logic [11:0] ADR_HOST = 12'h008;
  localparam logic [11:0] ADR_STAT = 12'h00c;
  localparam logic [2:0] TBL_SEL = 3'h1;
  // control bits and reset values
  localparam int CTRL_AUTH = 0;
  localparam int CTRL_EN = 1;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] RSVD_RST = 32'h0180_c200;
  localparam logic [NPORT-1:0] HOST_RST = 3'h4;
  // matching rule word 0 fields
  localparam int F_MODE = 30;
  localparam int F_ENB = 28;
  localparam int F_SD = 27;
  localparam int F_EQ = 26;
  localparam logic [1:0] MD_OFF = 2'h0;
  localparam logic [1:0] MD_L2 = 2'h1;
  localparam logic [1:0] MD_L3 = 2'h2;
  localparam logic [1:0] MD_L4 = 2'h3;
  localparam logic [1:0] ENB_CNT = 2'h0;
  // action rule fields
  localparam int A_PRIO_LSB = 4;
  localparam int A_PRIO_EN = 7;
  localparam int A_MAP_EN = 8;
  localparam int A_TU = 11;
  localparam int A_ALG = 12;
  // processing entry fields
  localparam int P_PTR_LSB = 16;
  // authentication frame addresses
  localparam logic [47:0] EAPOL_DA = 48'h0180_c200_0003;
  localparam logic [15:0] RSVD_OFS = 16'h0003;
  // count time base
  localparam int CLK_NS = 40;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] US_CYC_M1 = 5'(US_CYC - 1);
  localparam int MS_US = 1000;
  localparam logic [9:0] MS_US_M1 = 10'(MS_US - 1);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_MATCH = 3'h1,
    ST_PROC = 3'h3,
    ST_PEND = 3'h2,
    ST_ACT = 3'h6,
    ST_AWAIT = 3'h7,
    ST_DONE = 3'h5
  } pafe_state_t;
endpackage

// file: logic/pafe_cmp.sv
`timescale 1ns/1ps
module pafe_cmp (
  input wire logic [31:0] w0_i,
  input wire logic [31:0] w1_i,
  input wire logic [31:0] w2_i,
  input wire logic [47:0] da_i,
  input wire logic [47:0] sa_i,
  input wire logic [15:0] etype_i,
  input wire logic [31:0] ip_sa_i,
  input wire logic [31:0] ip_da_i,
  input wire logic [7:0] ip_proto_i,
  input wire logic [15:0] l4_sp_i,
  input wire logic [15:0] l4_dp_i,
  input wire logic [7:0] tcp_flags_i,
  input wire logic is_tcp_i,
  input wire logic is_udp_i,
  output logic match_o,
  output logic cnt_hit_o
);
  import pafe_pkg::*;
  logic [47:0] mac;
  logic [31:0] ip;
  logic [15:0] l4;
  logic mac_eq;
  logic typ_eq;
  logic raw;
  logic ok;
  logic cnt;
  always_comb begin
    mac = w0_i[F_SD] ? sa_i : da_i;
    ip = w0_i[F_SD] ? ip_sa_i : ip_da_i;
    l4 = w0_i[F_SD] ? l4_sp_i : l4_dp_i;
    mac_eq = mac == {w2_i[15:0], w1_i};
    typ_eq = etype_i == w0_i[15:0];
    raw = 1'b0;
    ok = 1'b1;
    // layer 2, 3 and 4 comparisons
    unique case (w0_i[F_MODE +: 2])
      MD_OFF: ok = 1'b0;
      MD_L2: begin
        unique case (w0_i[F_ENB +: 2])
          2'h1: raw = mac_eq;
          2'h2: raw = typ_eq;
          2'h0, 2'h3: raw = mac_eq && typ_eq;
        endcase
      end
      MD_L3: begin
        unique case (w0_i[F_ENB +: 2])
          2'h1: raw = (ip & w2_i) == (w1_i & w2_i);
          2'h2: raw = (ip_sa_i == w1_i) && (ip_da_i == w2_i);
          2'h0, 2'h3: ok = 1'b0;
        endcase
      end
      MD_L4: begin
        unique case (w0_i[F_ENB +: 2])
          2'h0: raw = ip_proto_i == w1_i[7:0];
          2'h1: raw = is_tcp_i && (l4 == w1_i[15:0]);
          2'h2: raw = is_udp_i && (l4 == w1_i[15:0]);
          2'h3: raw = is_tcp_i && ((tcp_flags_i & w2_i[7:0]) == (w1_i[7:0] & w2_i[7:0]));
        endcase
      end
    endcase
    cnt = (w0_i[F_MODE +: 2] == MD_L2) && (w0_i[F_ENB +: 2] == ENB_CNT);
    // count rules feed the counter, never the match vector
    match_o = ok && !cnt && (raw == w0_i[F_EQ]);
    cnt_hit_o = cnt && (raw == w0_i[F_EQ]);
  end
endmodule

// file: logic/pafe_mem.sv
`timescale 1ns/1ps
module pafe_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [pafe_pkg::TBL_AW-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o
);
  import pafe_pkg::*;
  logic [31:0] mem [TBL_WORDS];
  // sixteen entries of eight words each
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      for (int b = 0; b < 4; b++) begin
        if (we_i && sel_i[b]) begin
          mem[adr_i][b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      dat_o <= mem[adr_i];
    end
  end
endmodule

// file: logic/pafe_top.sv
`timescale 1ns/1ps
// How it works
// - authentication frame: destination is the fixed address or reserved base plus 0003 only.
// - authentication frames always go to the host port map.
// - unauthorized port forwards nothing except authentication frames.
// - one engine instance per port filters that port's ingress headers.
// - rules compare MAC, EtherType, masked IPv4, protocol, L4 ports, masked TCP flags.
// - table holds sixteen entries: match rule, action rule, processing entry.
// - a taken action may replace the normal port map and priority.
// - count-mode rules raise count events instead of forwarding actions.
// - watchdog mode pulses an event when no qualified frame arrives in time.
// - event-counter mode pulses an event after the programmed number of frames.
// - count value is action bits 10:0; that action never forwards.
// - action pointer chooses any action entry, independent of match index.
// - count rule uses the action entry at its own index.
// - processing entry is true only when all selected matches are true.
// - entries sharing an action pointer give the OR of their results.
// - all sixteen matching rules are evaluated for every frame.
// - lowest-numbered true processing entry supplies the action.
// - processing bits 19:16 point at action entry 0 to 15.
// - processing bits 15:0 select which matching rules join the AND.
// - matching rule with mode 00 is disabled and never true.
// - count time unit bit: 0 microseconds, 1 milliseconds.
module pafe_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hdr_valid_i,
  output logic hdr_ready_o,
  input wire logic [47:0] da_i,
  input wire logic [47:0] sa_i,
  input wire logic [15:0] etype_i,
  input wire logic [31:0] ip_sa_i,
  input wire logic [31:0] ip_da_i,
  input wire logic [7:0] ip_proto_i,
  input wire logic [15:0] l4_sp_i,
  input wire logic [15:0] l4_dp_i,
  input wire logic [7:0] tcp_flags_i,
  input wire logic is_tcp_i,
  input wire logic is_udp_i,
  input wire logic [pafe_pkg::NPORT-1:0] fwd_map_i,
  input wire logic [2:0] prio_i,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [pafe_pkg::NPORT-1:0] res_map_o,
  output logic [2:0] res_prio_o,
  output logic res_acl_hit_o,
  output logic res_eapol_o,
  output logic [pafe_pkg::NENT-1:0] count_event_o
);
  import pafe_pkg::*;

  typedef struct packed {
    pafe_state_t st;
    logic [3:0] ent;
    logic [1:0] wsel;
    logic dv;
    logic [3:0] dent;
    logic [2:0] dw;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [15:0] mvec;
    logic found;
    logic [3:0] aptr;
    logic [31:0] ctrl;
    logic [31:0] rsvd;
    logic [NPORT-1:0] host;
    logic bph;
    logic ack;
    logic btbl;
    logic [31:0] dat;
    logic [NPORT-1:0] rmap;
    logic [2:0] rprio;
    logic rhit;
    logic reap;
    logic [3:0] lastact;
    logic lasthit;
    logic lasteap;
    logic [4:0] us_cnt;
    logic [9:0] ms_cnt;
    logic [15:0] cmode;
    logic [15:0] tu;
    logic [15:0] alg;
    logic [15:0] armed;
    logic [15:0][10:0] cval;
    logic [15:0][10:0] cnt;
    logic [15:0] evt;
  } pafe_regs_t;

  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  pafe_regs_t s_r;
  pafe_regs_t s_nxt;
  logic [31:0] mem_rd;
  logic [TBL_AW-1:0] mem_adr;
  logic mem_we;
  logic cmp_match;
  logic cmp_cnt;
  logic req;
  logic is_tbl;
  logic tbl_go;
  logic reg_go;
  logic act_wr;
  logic m2_now;
  logic pr_now;
  logic eapol;
  logic tick_us;
  logic tick_ms;
  logic tick_i;
  logic [3:0] wr_ent;
  logic [3:0] pe_ptr;
  logic [15:0] pe_mask;
  logic [15:0] hitv;
  logic [NPORT-1:0] map_v;
  logic [2:0] prio_v;
  logic hit_v;

  assign req = wb_cyc_i && wb_stb_i && !s_r.bph && !s_r.ack;
  assign is_tbl = wb_adr_i[11:9] == TBL_SEL;
  assign tbl_go = req && is_tbl && (s_r.st == ST_IDLE);
  assign reg_go = req && !is_tbl;
  assign wr_ent = wb_adr_i[8:5];
  assign act_wr = tbl_go && wb_we_i && (wb_adr_i[4:2] == W_ACT);
  assign mem_we = tbl_go && wb_we_i;
  assign m2_now = s_r.dv && (s_r.dw == W_M2);
  assign pr_now = s_r.dv && (s_r.dw == W_PROC);
  assign pe_ptr = mem_rd[P_PTR_LSB +: 4];
  assign pe_mask = mem_rd[15:0];
  assign hitv = (m2_now && cmp_cnt) ? (16'h0001 << s_r.dent) : 16'h0000;
  assign tick_us = s_r.us_cnt == US_CYC_M1;
  assign tick_ms = tick_us && (s_r.ms_cnt == MS_US_M1);
  assign eapol = (da_i == EAPOL_DA) ||
                 ((da_i[47:16] == s_r.rsvd) && (da_i[15:0] == RSVD_OFS));

  // table port: bus in idle, walk otherwise
  always_comb begin
    mem_adr = {s_r.aptr, W_ACT};
    if (s_r.st == ST_IDLE) begin
      mem_adr = wb_adr_i[8:2];
    end else if (s_r.st == ST_MATCH) begin
      mem_adr = {s_r.ent, 1'b0, s_r.wsel};
    end else if (s_r.st == ST_PROC) begin
      mem_adr = {s_r.ent, W_PROC};
    end
  end

  pafe_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .sel_i(wb_sel_i),
    .adr_i(mem_adr),
    .dat_i(wb_dat_i),
    .dat_o(mem_rd)
  );

  // one comparator reused across all sixteen
  pafe_cmp u_cmp (
    .w0_i(s_r.w0),
    .w1_i(s_r.w1),
    .w2_i(mem_rd),
    .da_i(da_i),
    .sa_i(sa_i),
    .etype_i(etype_i),
    .ip_sa_i(ip_sa_i),
    .ip_da_i(ip_da_i),
    .ip_proto_i(ip_proto_i),
    .l4_sp_i(l4_sp_i),
    .l4_dp_i(l4_dp_i),
    .tcp_flags_i(tcp_flags_i),
    .is_tcp_i(is_tcp_i),
    .is_udp_i(is_udp_i),
    .match_o(cmp_match),
    .cnt_hit_o(cmp_cnt)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.dv = 1'b0;
    s_nxt.evt = 16'h0000;
    map_v = fwd_map_i;
    prio_v = prio_i;
    hit_v = 1'b0;
    tick_i = 1'b0;
    // bus slave
    if (s_r.ack) begin
      s_nxt.ack = 1'b0;
    end
    if (s_r.bph) begin
      s_nxt.bph = 1'b0;
      s_nxt.ack = 1'b1;
      if (s_r.btbl) begin
        s_nxt.dat = mem_rd;
      end
    end
    if (tbl_go || reg_go) begin
      s_nxt.bph = 1'b1;
      s_nxt.btbl = is_tbl;
      s_nxt.dat = 32'h0000_0000;
      if (reg_go) begin
        case (wb_adr_i)
          ADR_CTRL: begin
            s_nxt.dat = s_r.ctrl;
            if (wb_we_i) begin
              s_nxt.ctrl = bmerge(s_r.ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
            end
          end
          ADR_RSVD: begin
            s_nxt.dat = s_r.rsvd;
            if (wb_we_i) begin
              s_nxt.rsvd = bmerge(s_r.rsvd, wb_dat_i, wb_sel_i);
            end
          end
          ADR_HOST: begin
            s_nxt.dat = 32'(s_r.host);
            if (wb_we_i && wb_sel_i[0]) begin
              s_nxt.host = wb_dat_i[NPORT-1:0];
            end
          end
          ADR_STAT: begin
            s_nxt.dat = {s_r.armed, 10'h000, s_r.lasteap, s_r.lasthit, s_r.lastact};
          end
          default: begin
            s_nxt.dat = 32'h0000_0000;
          end
        endcase
      end
    end
    // walk through the table
    unique case (s_r.st)
      ST_IDLE: begin
        if (hdr_valid_i && !tbl_go) begin
          s_nxt.st = ST_MATCH;
          s_nxt.ent = 4'h0;
          s_nxt.wsel = 2'h0;
          s_nxt.mvec = 16'h0000;
          s_nxt.found = 1'b0;
          s_nxt.aptr = 4'h0;
        end
      end
      ST_MATCH: begin
        s_nxt.dv = 1'b1;
        s_nxt.dent = s_r.ent;
        s_nxt.dw = {1'b0, s_r.wsel};
        if (s_r.wsel == 2'h2) begin
          s_nxt.wsel = 2'h0;
          s_nxt.ent = s_r.ent + 4'h1;
          if (s_r.ent == 4'hf) begin
            s_nxt.st = ST_PROC;
          end
        end else begin
          s_nxt.wsel = s_r.wsel + 2'h1;
        end
      end
      ST_PROC: begin
        s_nxt.dv = 1'b1;
        s_nxt.dent = s_r.ent;
        s_nxt.dw = W_PROC;
        s_nxt.ent = s_r.ent + 4'h1;
        if (s_r.ent == 4'hf) begin
          s_nxt.st = ST_PEND;
        end
      end
      ST_PEND: s_nxt.st = ST_ACT;
      ST_ACT: s_nxt.st = ST_AWAIT;
      ST_AWAIT: begin
        hit_v = s_r.found && s_r.ctrl[CTRL_EN] && !s_r.cmode[s_r.aptr];
        if (hit_v) begin
          if (mem_rd[A_MAP_EN]) begin
            map_v = mem_rd[NPORT-1:0];
          end
          if (mem_rd[A_PRIO_EN]) begin
            prio_v = mem_rd[A_PRIO_LSB +: 3];
          end
        end
        if (!s_r.ctrl[CTRL_AUTH]) begin
          map_v = '0;
        end
        if (eapol) begin
          map_v = s_r.host;
        end
        s_nxt.rmap = map_v;
        s_nxt.rprio = prio_v;
        s_nxt.rhit = hit_v;
        s_nxt.reap = eapol;
        s_nxt.lastact = s_r.aptr;
        s_nxt.lasthit = hit_v;
        s_nxt.lasteap = eapol;
        s_nxt.st = ST_DONE;
      end
      ST_DONE: begin
        if (res_ready_i) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // read-back pipeline
    if (s_r.dv && (s_r.dw == W_M0)) begin
      s_nxt.w0 = mem_rd;
    end
    if (s_r.dv && (s_r.dw == W_M1)) begin
      s_nxt.w1 = mem_rd;
    end
    if (m2_now) begin
      s_nxt.mvec[s_r.dent] = cmp_match;
    end
    // first true entry wins, later entries naming the same action are an OR
    if (pr_now && !s_r.found && (pe_mask != 16'h0000) &&
        ((pe_mask & ~s_r.mvec) == 16'h0000)) begin
      s_nxt.found = 1'b1;
      s_nxt.aptr = pe_ptr;
    end
    // shadow copies of count configuration
    if (mem_we && (wb_adr_i[4:2] == W_M0)) begin
      s_nxt.cmode[wr_ent] = (wb_dat_i[F_MODE +: 2] == MD_L2) &&
                            (wb_dat_i[F_ENB +: 2] == ENB_CNT);
    end
    if (act_wr) begin
      s_nxt.cval[wr_ent] = wb_dat_i[10:0];
      s_nxt.tu[wr_ent] = wb_dat_i[A_TU];
      s_nxt.alg[wr_ent] = wb_dat_i[A_ALG];
    end
    // time base
    s_nxt.us_cnt = tick_us ? 5'h00 : s_r.us_cnt + 5'h01;
    if (tick_us) begin
      s_nxt.ms_cnt = tick_ms ? 10'h000 : s_r.ms_cnt + 10'h001;
    end
    // count engines
    for (int i = 0; i < NENT; i++) begin
      tick_i = s_r.tu[i] ? tick_ms : tick_us;
      if (act_wr && (wr_ent == 4'(i))) begin
        s_nxt.cnt[i] = wb_dat_i[10:0];
        s_nxt.armed[i] = !wb_dat_i[A_ALG];
      end else if (hitv[i]) begin
        if (s_r.alg[i]) begin
          if (s_r.cnt[i] <= 11'h001) begin
            s_nxt.evt[i] = 1'b1;
            s_nxt.cnt[i] = s_r.cval[i];
          end else begin
            s_nxt.cnt[i] = s_r.cnt[i] - 11'h001;
          end
        end else begin
          s_nxt.cnt[i] = s_r.cval[i];
          s_nxt.armed[i] = 1'b1;
        end
      end else if (s_r.cmode[i] && !s_r.alg[i] && s_r.armed[i] && tick_i) begin
        if (s_r.cnt[i] <= 11'h001) begin
          s_nxt.evt[i] = 1'b1;
          s_nxt.armed[i] = 1'b0;
          s_nxt.cnt[i] = 11'h000;
        end else begin
          s_nxt.cnt[i] = s_r.cnt[i] - 11'h001;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.rsvd <= RSVD_RST;
      s_r.host <= HOST_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign res_valid_o = s_r.st == ST_DONE;
  assign hdr_ready_o = ce_i && res_ready_i && (s_r.st == ST_DONE);
  assign res_map_o = s_r.rmap;
  assign res_prio_o = s_r.rprio;
  assign res_acl_hit_o = s_r.rhit;
  assign res_eapol_o = s_r.reap;
  assign count_event_o = s_r.evt;

  a_eapol_host: assert property (@(posedge clk_i) disable iff (rst_i)
    res_valid_o && (da_i == EAPOL_DA) |-> res_eapol_o && (res_map_o == s_r.host))
    else $error("authentication frame not steered to host");

  a_unauth_block: assert property (@(posedge clk_i) disable iff (rst_i)
    res_valid_o && !s_r.ctrl[CTRL_AUTH] && !res_eapol_o |-> res_map_o == '0)
    else $error("unauthorized port forwarded a user frame");

  a_pass_through: assert property (@(posedge clk_i) disable iff (rst_i)
    res_valid_o && !res_acl_hit_o && !res_eapol_o && s_r.ctrl[CTRL_AUTH]
    |-> (res_map_o == fwd_map_i) && (res_prio_o == prio_i))
    else $error("decision changed with no action taken");

  a_walk_all: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (s_r.st == ST_MATCH) && (s_r.ent == 4'hf) && (s_r.wsel == 2'h2)
    |=> s_r.st == ST_PROC)
    else $error("match walk left before last rule");

  a_off_rule: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && m2_now && (s_r.w0[F_MODE +: 2] == MD_OFF) |=> !s_r.mvec[$past(s_r.dent)])
    else $error("disabled rule produced a match");

  a_and_take: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pr_now && !s_r.found && (pe_mask != 16'h0000) &&
    ((pe_mask & ~s_r.mvec) == 16'h0000) |=> s_r.found && (s_r.aptr == $past(pe_ptr)))
    else $error("true processing entry not taken");

  a_first_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_r.found && (s_r.st == ST_PROC) |=> s_r.found && $stable(s_r.aptr))
    else $error("later entry overrode a higher priority one");

  a_count_nofwd: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (s_r.st == ST_AWAIT) && s_r.found && s_r.cmode[s_r.aptr] |=> !res_acl_hit_o)
    else $error("count action applied as forwarding");

  a_event_count: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && m2_now && cmp_cnt && s_r.alg[s_r.dent] && (s_r.cnt[s_r.dent] <= 11'h001) &&
    !act_wr |=> count_event_o[$past(s_r.dent)])
    else $error("event counter did not fire");

  a_watchdog: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_r.cmode[0] && !s_r.alg[0] && s_r.armed[0] && (s_r.cnt[0] == 11'h001) &&
    !s_r.tu[0] && tick_us && !hitv[0] && !act_wr |=> count_event_o[0])
    else $error("watchdog expiry missed");

  a_ms_unit: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_r.cmode[0] && !s_r.alg[0] && s_r.armed[0] && s_r.tu[0] && tick_us &&
    !tick_ms && !hitv[0] && !act_wr |=> $stable(s_r.cnt[0]))
    else $error("millisecond counter stepped on a microsecond tick");
endmodule

// file: tb/pafe_far.sv
`timescale 1ns/1ps
module pafe_far (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [3:0] stall_i,
  input wire logic hdr_ready_i,
  input wire logic res_valid_i,
  output logic hdr_valid_o,
  output logic res_ready_o
);
  logic [3:0] wait_r;
  // header held until taken; result taken after a stall
  always_ff @(posedge clk_i) begin
    if (rst_i || hdr_ready_i) begin
      hdr_valid_o <= 1'b0;
      res_ready_o <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      if (go_i)
        hdr_valid_o <= 1'b1;
      if (res_valid_i && wait_r == stall_i)
        res_ready_o <= 1'b1;
      else if (res_valid_i)
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pafe_pkg::*;
  localparam logic [47:0] MAC_A = 48'h0200_0000_00a1;
  localparam logic [47:0] MAC_B = 48'h0200_0000_00b2;
  localparam logic [47:0] MAC_C = 48'h0200_0000_00c3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic go = 1'b0;
  logic [3:0] stall = 4'h0;
  logic [47:0] da = 48'h0000_0000_0000;
  logic [47:0] sa = 48'h0000_0000_0000;
  logic [15:0] et = 16'h0000;
  logic [31:0] hx = 32'h0000_0000;
  logic hv, hr, rv, rr, rhit, reap;
  logic [2:0] rmap, rprio;
  logic [15:0] cev;
  logic [15:0] ev = 16'h0000;
  logic [7:0] res;
  int failures = 0;
  int compares = 0;
  int cyc_n = 0;
  logic [31:0] w0_t [5] = '{32'h5400_0000, 32'h6400_88b5, 32'h5c00_0000, 32'h4400_88b6,
    32'h2400_88b5};
  logic [31:0] w4_t [4] = '{32'h0006_0012, 32'h0005_0003, 32'h0002_0002, 32'h0005_0004};

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) ev <= ev | cev;
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      print_verdict();
    end
  end

  pafe_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hdr_valid_i(hv), .hdr_ready_o(hr), .da_i(da), .sa_i(sa), .etype_i(et),
    .ip_sa_i(hx), .ip_da_i(~hx), .ip_proto_i(hx[7:0]), .l4_sp_i(hx[15:0]),
    .l4_dp_i(hx[31:16]), .tcp_flags_i(hx[15:8]), .is_tcp_i(hx[0]), .is_udp_i(hx[1]),
    .fwd_map_i(3'h3), .prio_i(3'h2), .res_valid_o(rv), .res_ready_i(rr), .res_map_o(rmap),
    .res_prio_o(rprio), .res_acl_hit_o(rhit), .res_eapol_o(reap), .count_event_o(cev));
  pafe_far far (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .stall_i(stall), .hdr_ready_i(hr),
    .res_valid_i(rv), .hdr_valid_o(hv), .res_ready_o(rr));

  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_res(input string nm, input logic [7:0] exp);
    compares++;
    if (res !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, res);
    end
  endtask

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 200);
    q = rdat;
    if (n >= 200)
      failures++;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, q);
  endtask

  task automatic frame(input logic [47:0] fda, fsa, input logic [15:0] fet,
    input logic [3:0] fst);
    int n;
    n = 0;
    da <= fda;
    sa <= fsa;
    et <= fet;
    stall <= fst;
    hx <= hx + 32'h0101_0101;
    go <= 1'b1;
    do begin
      @(posedge clk_i);
      go <= 1'b0;
      n++;
    end while (hr !== 1'b1 && n < 300);
    res = {rmap, rprio, rhit, reap};
    if (n >= 300)
      failures++;
    da <= ~fda;
    sa <= ~fsa;
    @(posedge clk_i);
  endtask

  function automatic logic [31:0] tv(input int e, input int w);
    logic [47:0] m;
    m = (e == 0) ? MAC_A : (e == 2) ? MAC_C : MAC_B;
    case (w)
      0: return (e < 5) ? w0_t[e] : 32'h0000_0000;
      1: return (e < 4) ? m[31:0] : 32'h0000_0000;
      2: return (e < 4) ? {16'h0000, m[47:32]} : 32'h0000_0000;
      3: return (e == 2) ? 32'h0000_01f2 : (e == 3) ? 32'h0000_1002 :
        (e == 5) ? 32'h0000_0101 : (e == 6) ? 32'h0000_0103 : 32'h0000_0000;
      default: return (e < 4) ? w4_t[e] : 32'h0000_0000;
    endcase
  endfunction

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("ctrl", ADR_CTRL, CTRL_RST);
    rd("rsvd", ADR_RSVD, RSVD_RST);
    rd("host", ADR_HOST, 32'(HOST_RST));
    wb(1'b1, 12'h0f0, 32'hffff_ffff);
    rd("unmapped", 12'h0f0, 32'h0000_0000);
    for (int e = 0; e < 16; e++)
      for (int w = 0; w < 5; w++)
        wb(1'b1, 12'h200 + 12'(e * 32 + w * 4), tv(e, w));
    frame(48'h0180_c200_0003, 48'h0, 16'h0000, 4'h0);
    chk_res("eapol fixed", {3'h4, 3'h2, 2'b01});
    frame(MAC_B, 48'h0, 16'h0000, 4'h2);
    chk_res("blocked", {3'h0, 3'h2, 2'b00});
    wb(1'b1, ADR_RSVD, 32'h1122_3344);
    frame(48'h1122_3344_0003, 48'h0, 16'h0000, 4'h3);
    chk_res("eapol reserved", {3'h4, 3'h2, 2'b01});
    wb(1'b1, ADR_CTRL, 32'h0000_0003);
    frame(MAC_A, 48'h0, 16'h88b5, 4'h0);
    chk_res("and lowest", {3'h1, 3'h2, 2'b10});
    frame(MAC_B, 48'h0, 16'h88b5, 4'h1);
    chk_res("pointer", {3'h2, 3'h7, 2'b10});
    frame(MAC_B, MAC_C, 16'h0000, 4'h0);
    chk_res("or", {3'h1, 3'h2, 2'b10});
    frame(MAC_B, 48'h0, 16'h0000, 4'h2);
    chk_res("no hit", {3'h3, 3'h2, 2'b00});
    chk("events none", 32'h0000_0000, 32'(ev));
    frame(MAC_B, 48'h0, 16'h88b6, 4'h0);
    chk_res("count frame", {3'h3, 3'h2, 2'b00});
    chk("events first", 32'h0000_0000, 32'(ev));
    frame(MAC_B, 48'h0, 16'h88b6, 4'h4);
    chk("events second", 32'h0000_0008, 32'(ev));
    wb(1'b1, 12'h2b0, 32'h0003_0001);
    frame(MAC_A, 48'h0, 16'h0000, 4'h0);
    chk_res("count pointer", {3'h3, 3'h2, 2'b00});
    rd("status", ADR_STAT, 32'hfff7_0003);
    wb(1'b1, 12'h20c, 32'h0000_0802);
    wb(1'b1, 12'h200, 32'h4400_88b6);
    repeat (60) @(posedge clk_i);
    chk("events ms", 32'h0000_0008, 32'(ev));
    wb(1'b1, 12'h20c, 32'h0000_0002);
    repeat (60) @(posedge clk_i);
    chk("events watchdog", 32'h0000_0009, 32'(ev));
    print_verdict();
  end
endmodule
